//--- hdl/lcd_key_scan_controller.sv
// key scan controller sharing segment pins with key drive lines
//
// What this block does
// - power-on or clock stop: all segments low
// - power-on or clock stop: both commons low
// - CE reset, halt: segments run, ports hold
// - CE reset, halt: commons keep normal waveform
// - up to 64 keys: 16 drives, 4 returns
// - drive pins time-share segment and key levels
// - drive register loaded from data buffer, shown
// - port mode: drive register feeds pin levels
// - display off, port select 0: no key drive, pins low
// - returns sampled only during drive window
// - return snapshot read at bank 0 73H
// - drive register at 42H, bit per pin
// - window: bit 1 high, bit 0 low
// - port register is the drive register
// - 220 us drive window every 4 ms
// - done flag: set at window end, cleared
// - port select 1 means general outputs
// - key drive needs display and drive enables
`timescale 1ns/10ps
`include "lcd_key_scan_params.svh"
module lcd_key_scan_controller
    import lcd_key_scan_pkg::*;
#(
    parameter int PERIOD_CYC = `LKS_PERIOD_CYC,
    parameter int WINDOW_CYC = `LKS_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce_reset,
    input wire logic halt,
    input wire logic clock_stop,
    input wire logic display_enable_flag,
    input wire logic drive_enable_flag,
    input wire logic port_select_flag,
    input wire logic [29:0] seg_wave,
    input wire logic [1:0] com_wave,
    input wire logic [6:0] periph_addr,
    input wire logic periph_put,
    input wire logic periph_get,
    input wire logic [15:0] dbf_wdata,
    output logic [15:0] periph_rdata,
    input wire logic [6:0] mem_addr,
    input wire logic mem_rd,
    output logic [3:0] mem_rdata,
    input wire logic [6:0] rf_addr,
    input wire logic rf_peek,
    output logic [3:0] rf_rdata,
    input wire logic [3:0] key_return_pins,
    output logic [15:0] shared_port_outputs,
    output logic [13:0] upper_seg_outputs,
    output logic backplane_line_one,
    output logic backplane_line_zero,
    output logic return_pulldown_en
);

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    // port mode wins over display and scan; clock stop wins over all
    wire port_mode;
    wire display_on;
    wire scan_on;
    wire pins_off;

    assign pins_off = clock_stop;
    assign port_mode = port_select_flag && !pins_off;
    assign display_on = display_enable_flag && !pins_off;
    assign scan_on = display_on && drive_enable_flag && !port_select_flag;

    // ----------------------------------------------------------------
    // scan time base
    // ----------------------------------------------------------------
    scan_phase_e phase;
    logic window_end;
    wire in_window;
    wire drive_now;
    wire window_done;

    scan_timer #(
        .PERIOD_CYC(PERIOD_CYC),
        .WINDOW_CYC(WINDOW_CYC)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .halt_count(clock_stop),
        .phase(phase),
        .window_end(window_end)
    );

    assign in_window = (phase == DRIVE_PHASE);
    assign drive_now = in_window && scan_on;
    assign window_done = window_end && scan_on;

    // ----------------------------------------------------------------
    // return sampling
    // ----------------------------------------------------------------
    return_nib_t return_snap;

    // four return lines by sixteen drives
    return_sampler u_sampler (
        .clk(clk),
        .reset(reset),
        .return_pins(key_return_pins),
        .sample_en(drive_now),
        .window_end(window_done),
        .snapshot(return_snap)
    );

    // ----------------------------------------------------------------
    // register access decode
    // ----------------------------------------------------------------
    wire drive_hit;
    wire drive_write;
    wire drive_read;
    wire return_read;
    wire judge_read;

    assign drive_hit = (periph_addr == `LKS_PERIPH_DRIVE);
    assign drive_write = periph_put && drive_hit;
    assign drive_read = periph_get && drive_hit;
    assign return_read = mem_rd && (mem_addr == `LKS_MEM_RETURN);
    assign judge_read = rf_peek && (rf_addr == `LKS_RF_JUDGE);

    // ----------------------------------------------------------------
    // drive register
    // ----------------------------------------------------------------
    // CE reset leaves it alone so port pins keep their values
    drive_word_t key_drive_data_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            key_drive_data_r <= `LKS_DRIVE_RESET;
        end else if (drive_write) begin
            key_drive_data_r <= dbf_wdata;
        end
    end

    // ----------------------------------------------------------------
    // sample done flag
    // ----------------------------------------------------------------
    logic sample_done_r;
    logic sample_done_nxt;
    wire done_clear;

    assign done_clear = drive_write || judge_read;
    assign sample_done_nxt = window_done ? 1'b1 : (done_clear ? 1'b0 : sample_done_r);

    always_ff @(posedge clk) begin
        if (reset) begin
            sample_done_r <= 1'b0;
        end else begin
            sample_done_r <= sample_done_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [15:0] periph_rdata_r;
    logic [3:0] mem_rdata_r;
    logic [3:0] rf_rdata_r;
    wire [3:0] judge_word;

    assign judge_word = 4'(sample_done_r) << `LKS_JUDGE_DONE_BIT;

    // unmapped reads return zero
    wire [15:0] periph_sel;
    wire [3:0] mem_sel;
    wire [3:0] rf_sel;

    assign periph_sel = drive_read ? key_drive_data_r : 16'h0000;
    assign mem_sel = return_read ? return_snap : 4'h0;
    assign rf_sel = judge_read ? judge_word : 4'h0;

    always_ff @(posedge clk) begin
        if (reset) begin
            periph_rdata_r <= 16'h0000;
            mem_rdata_r <= 4'h0;
            rf_rdata_r <= 4'h0;
        end else begin
            if (periph_get) begin
                periph_rdata_r <= periph_sel;
            end
            // snapshot read while it stands still
            if (mem_rd) begin
                mem_rdata_r <= mem_sel;
            end
            if (rf_peek) begin
                rf_rdata_r <= rf_sel;
            end
        end
    end

    assign periph_rdata = periph_rdata_r;
    assign mem_rdata = mem_rdata_r;
    assign rf_rdata = rf_rdata_r;

    // ----------------------------------------------------------------
    // shared drive pins
    // ----------------------------------------------------------------
    // halt and CE reset change nothing here: segments keep running
    // and port levels come from the untouched drive register
    logic [15:0] shared_nxt;
    logic [15:0] shared_r;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_shared
            assign shared_nxt[gi] = port_mode ? key_drive_data_r[gi] :
                                    !display_on ? 1'b0 :
                                    drive_now ? key_drive_data_r[gi] :
                                    seg_wave[gi];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            shared_r <= 16'h0000;
        end else begin
            shared_r <= shared_nxt;
        end
    end

    assign shared_port_outputs = shared_r;

    // ----------------------------------------------------------------
    // upper segment pins
    // ----------------------------------------------------------------
    // these carry a zero drive level during the window
    logic [13:0] upper_nxt;
    logic [13:0] upper_r;

    assign upper_nxt = (!display_on || drive_now) ? 14'h0000 : seg_wave[29:16];

    always_ff @(posedge clk) begin
        if (reset) begin
            upper_r <= 14'h0000;
        end else begin
            upper_r <= upper_nxt;
        end
    end

    assign upper_seg_outputs = upper_r;

    // ----------------------------------------------------------------
    // backplane lines
    // ----------------------------------------------------------------
    logic [1:0] com_r;
    wire [1:0] com_nxt;

    assign com_nxt = pins_off ? 2'h0 : com_wave;

    always_ff @(posedge clk) begin
        if (reset) begin
            com_r <= 2'h0;
        end else begin
            com_r <= com_nxt;
        end
    end

    assign backplane_line_one = com_r[1];
    assign backplane_line_zero = com_r[0];

    // ----------------------------------------------------------------
    // return pull-downs
    // ----------------------------------------------------------------
    logic pulldown_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            pulldown_r <= 1'b0;
        end else begin
            pulldown_r <= drive_now;
        end
    end

    assign return_pulldown_en = pulldown_r;

    // ----------------------------------------------------------------
    // status inputs with no effect on this block
    // ----------------------------------------------------------------
    // CE reset and halt leave pins running; kept for the record only
    wire unused_status;
    assign unused_status = ce_reset ^ halt;

endmodule : lcd_key_scan_controller

//--- hdl/return_sampler.sv
// key return inputs: synchroniser, window latch and port snapshot
`timescale 1ns/10ps
`include "lcd_key_scan_params.svh"
module return_sampler
    import lcd_key_scan_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] return_pins,
    input wire logic sample_en,
    input wire logic window_end,
    output return_nib_t snapshot
);

    return_nib_t meta_r;
    return_nib_t sync_r;
    return_nib_t latch_r;
    return_nib_t snap_r;

    always_ff @(posedge clk) begin
        meta_r <= return_pins;
        sync_r <= meta_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            latch_r <= `LKS_RETURN_RESET;
        end else if (sample_en) begin
            latch_r <= sync_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            snap_r <= `LKS_RETURN_RESET;
        end else if (window_end) begin
            snap_r <= latch_r;
        end
    end

    assign snapshot = snap_r;

endmodule : return_sampler

//--- hdl/scan_timer.sv
// time base: drive window at the start of each scan period
`timescale 1ns/10ps
`include "lcd_key_scan_params.svh"
module scan_timer
    import lcd_key_scan_pkg::*;
#(
    parameter int PERIOD_CYC = `LKS_PERIOD_CYC,
    parameter int WINDOW_CYC = `LKS_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic halt_count,
    output scan_phase_e phase,
    output logic window_end
);

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
    localparam logic [CW-1:0] WIN = CW'(WINDOW_CYC);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    scan_phase_e phase_r;
    scan_phase_e phase_nxt;
    logic end_r;
    logic end_nxt;

    assign cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
    assign phase_nxt = (cnt_nxt < WIN) ? DRIVE_PHASE : SEG_PHASE;
    assign end_nxt = (phase_r == DRIVE_PHASE) && (phase_nxt == SEG_PHASE);

    always_ff @(posedge clk) begin
        if (reset || halt_count) begin
            // park at the last count so the first window is full length
            cnt_r <= LAST;
            phase_r <= SEG_PHASE;
            end_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            end_r <= end_nxt;
        end
    end

    assign phase = phase_r;
    assign window_end = end_r;

endmodule : scan_timer

//--- shared/lcd_key_scan_params.svh
// timing, address and reset constants of the key scan controller
`ifndef LCD_KEY_SCAN_PARAMS_SVH
`define LCD_KEY_SCAN_PARAMS_SVH

// ----------------------------------------------------------------
// clock and scan timing
// ----------------------------------------------------------------
`define LKS_CLK_HZ 20000000
`define LKS_WINDOW_NS 220000
`define LKS_PERIOD_NS 4000000
// least time: round up to whole cycles
`define LKS_WINDOW_CYC ((`LKS_WINDOW_NS * (`LKS_CLK_HZ / 1000000) + 999) / 1000)
`define LKS_PERIOD_CYC ((`LKS_PERIOD_NS * (`LKS_CLK_HZ / 1000000) + 999) / 1000)

// ----------------------------------------------------------------
// addresses
// ----------------------------------------------------------------
`define LKS_PERIPH_DRIVE 7'h42
`define LKS_MEM_RETURN 7'h73
`define LKS_RF_JUDGE 7'h16

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define LKS_JUDGE_DONE_BIT 0
`define LKS_DRIVE_RESET 16'h0000
`define LKS_RETURN_RESET 4'h0

`endif

//--- shared/lcd_key_scan_pkg.sv
// types shared by the key scan controller modules
package lcd_key_scan_pkg;

    // ----------------------------------------------------------------
    // scan phase
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        SEG_PHASE = 1'b0,
        DRIVE_PHASE = 1'b1
    } scan_phase_e;

    typedef logic [15:0] drive_word_t;
    typedef logic [3:0] return_nib_t;

endpackage : lcd_key_scan_pkg

//--- verif/key_matrix.sv
// key switch matrix with a diode on each drive line
`timescale 1ns/10ps
module key_matrix (
    input wire logic clk,
    input wire logic [63:0] keys,
    input wire logic [15:0] shared_port_outputs,
    input wire logic return_pulldown_en,
    output logic [3:0] key_return_pins
);
    logic [3:0] hit;
    logic [3:0] float_r = 4'h5;
    always_comb begin
        hit = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (shared_port_outputs[i]) hit = hit | keys[i*4 +: 4];
        end
    end
    // undriven returns wander
    always @(posedge clk) float_r <= ~float_r;
    assign key_return_pins = return_pulldown_en ? hit : float_r;
endmodule : key_matrix

//--- verif/lcd_key_scan_props.sv
// assertion checker for the key scan controller ports
`timescale 1ns/10ps
`include "lcd_key_scan_params.svh"
module lcd_key_scan_props
    import lcd_key_scan_pkg::*;
#(
    parameter int PERIOD_CYC = `LKS_PERIOD_CYC,
    parameter int WINDOW_CYC = `LKS_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clock_stop,
    input wire logic display_enable_flag,
    input wire logic drive_enable_flag,
    input wire logic port_select_flag,
    input wire logic [29:0] seg_wave,
    input wire logic [1:0] com_wave,
    input wire logic [6:0] periph_addr,
    input wire logic periph_put,
    input wire logic [15:0] dbf_wdata,
    input wire logic [15:0] shared_port_outputs,
    input wire logic [13:0] upper_seg_outputs,
    input wire logic backplane_line_one,
    input wire logic backplane_line_zero,
    input wire logic return_pulldown_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [13:0] seg_hi;
    logic [15:0] seg_lo;
    logic [15:0] len_r;
    logic [15:0] len_nxt;
    assign seg_hi = seg_wave[29:16];
    assign seg_lo = seg_wave[15:0];
    assign len_nxt = return_pulldown_en ? len_r + 16'h0001 : 16'h0000;
    always_ff @(posedge clk) begin
        if (reset) len_r <= 16'h0000;
        else len_r <= len_nxt;
    end
    // ----------------------------------------------------------------
    // port mode write steps
    // ----------------------------------------------------------------
    sequence s_port_put;
        periph_put && periph_addr == 7'h42 && port_select_flag && !clock_stop;
    endsequence
    sequence s_port_hold;
        port_select_flag && !clock_stop && !periph_put;
    endsequence
    AST_STOP_PINS: assert property (clock_stop [*2] |->
        shared_port_outputs == 16'h0000 && upper_seg_outputs == 14'h0000)
        else $error("pins not low in clock stop");
    AST_STOP_COM: assert property (clock_stop [*2] |->
        !backplane_line_one && !backplane_line_zero)
        else $error("commons not low in clock stop");
    AST_COM_RUN: assert property (display_enable_flag && !clock_stop |=>
        {backplane_line_one, backplane_line_zero} == $past(com_wave))
        else $error("commons do not follow waveform");
    AST_SEG_RUN: assert property (display_enable_flag && !clock_stop ##1
        !return_pulldown_en |-> upper_seg_outputs == $past(seg_hi))
        else $error("upper segments do not follow waveform");
    AST_PULL_GATE: assert property (return_pulldown_en |->
        $past(display_enable_flag) && $past(drive_enable_flag)
        && !$past(port_select_flag) && !$past(clock_stop))
        else $error("window without enables");
    AST_WIN_UPPER: assert property (return_pulldown_en |->
        upper_seg_outputs == 14'h0000)
        else $error("upper pins not low in window");
    AST_SEG_SHARED: assert property (display_enable_flag && !port_select_flag
        && !clock_stop ##1 !return_pulldown_en |-> shared_port_outputs == $past(seg_lo))
        else $error("shared pins do not follow waveform");
    AST_PORT_WRITE: assert property (s_port_put ##1 s_port_hold |=>
        shared_port_outputs == $past(dbf_wdata, 2))
        else $error("port pins miss written word");
    AST_DISP_OFF: assert property ((!display_enable_flag && !port_select_flag
        && !clock_stop) [*2] |-> shared_port_outputs == 16'h0000 && !return_pulldown_en)
        else $error("drive active with display off");
    AST_WIN_LEN: assert property (len_r <= 16'(WINDOW_CYC))
        else $error("window too long");
endmodule : lcd_key_scan_props

bind lcd_key_scan_controller lcd_key_scan_props #(
    .PERIOD_CYC(PERIOD_CYC),
    .WINDOW_CYC(WINDOW_CYC)
) u_lcd_key_scan_props (.*);

//--- verif/tb_lcd_key_scan_controller.sv
// self-checking bench for the key scan controller
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_lcd_key_scan_controller
    import lcd_key_scan_pkg::*;
;
    localparam int P = 40;
    localparam int W = 6;
    localparam logic [2:0] CFG [3] = '{3'b010, 3'b100, 3'b111};
    typedef struct {int k; logic [15:0] v;} note_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce_reset = 1'b0;
    logic halt = 1'b0;
    logic clock_stop = 1'b0;
    logic display_enable_flag = 1'b0;
    logic drive_enable_flag = 1'b0;
    logic port_select_flag = 1'b0;
    logic [29:0] seg_wave = 30'h0;
    logic [1:0] com_wave = 2'h0;
    logic [6:0] periph_addr = 7'h00;
    logic periph_put = 1'b0;
    logic periph_get = 1'b0;
    logic [15:0] dbf_wdata = 16'h0000;
    logic [15:0] periph_rdata;
    logic [6:0] mem_addr = 7'h00;
    logic mem_rd = 1'b0;
    logic [3:0] mem_rdata;
    logic [6:0] rf_addr = 7'h00;
    logic rf_peek = 1'b0;
    logic [3:0] rf_rdata;
    logic [3:0] key_return_pins;
    logic [15:0] shared_port_outputs;
    logic [13:0] upper_seg_outputs;
    logic backplane_line_one;
    logic backplane_line_zero;
    logic return_pulldown_en;
    logic [63:0] keys = 64'h0;
    logic [31:0] rs = 32'h03BBFBC7;
    logic [15:0] d;
    note_s n;
    note_s q[$];
    int failures = 0;
    int checks = 0;
    int len;
    int hits;
    time t0;

    lcd_key_scan_controller #(.PERIOD_CYC(P), .WINDOW_CYC(W)) u_lcd_key_scan_controller (.*);
    key_matrix u_key_matrix (.*);

    always #25 clk = ~clk;
    always @(posedge clk) begin
        seg_wave <= 30'(rnd());
        com_wave <= 2'(rnd());
    end

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    function automatic logic [15:0] hit(logic [15:0] v);
        logic [3:0] h;
        h = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) h = h | keys[i*4 +: 4];
        end
        return {12'h000, h};
    endfunction : hit
    task automatic wr(logic [6:0] a, logic [15:0] v);
        @(posedge clk);
        periph_put <= 1'b1;
        periph_addr <= a;
        dbf_wdata <= v;
        @(posedge clk);
        periph_put <= 1'b0;
    endtask : wr
    // k: 0 drive word, 1 return port, 2 judge, 3 pins
    task automatic rd(int k, logic [6:0] a, logic [15:0] e);
        @(posedge clk);
        periph_get <= (k == 0);
        mem_rd <= (k == 1);
        rf_peek <= (k == 2);
        periph_addr <= a;
        mem_addr <= a;
        rf_addr <= a;
        @(posedge clk);
        periph_get <= 1'b0;
        mem_rd <= 1'b0;
        rf_peek <= 1'b0;
        q.push_back('{k, e});
    endtask : rd
    task automatic pins(logic [15:0] e);
        @(posedge clk);
        q.push_back('{3, e});
    endtask : pins
    task automatic wait_pd(logic lvl);
        int i;
        i = 0;
        while (return_pulldown_en !== lvl && i < 2 * P) begin
            @(negedge clk);
            i++;
        end
        `CHK(i < 2 * P, 1'b1)
    endtask : wait_pd
    task automatic fin(string s);
        $display("test %s done", s);
    endtask : fin
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    always @(negedge clk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            case (n.k)
                0: `CHK(periph_rdata, n.v)
                1: `CHK(mem_rdata, n.v[3:0])
                2: `CHK(rf_rdata, n.v[3:0])
                default: `CHK(shared_port_outputs, n.v)
            endcase
        end
    end

    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(0, 7'h42, 16'h0000);
        rd(1, 7'h73, 16'h0000);
        rd(2, 7'h16, 16'h0000);
        fin("reset");
        port_select_flag <= 1'b1;
        d = 16'(rnd());
        wr(7'h42, d);
        pins(d);
        wr(7'h43, ~d);
        rd(0, 7'h42, d);
        rd(1, 7'h74, 16'h0000);
        ce_reset <= 1'b1;
        halt <= 1'b1;
        repeat (4) @(posedge clk);
        pins(d);
        fin("port");
        ce_reset <= 1'b0;
        halt <= 1'b0;
        port_select_flag <= 1'b0;
        display_enable_flag <= 1'b1;
        drive_enable_flag <= 1'b1;
        wait_pd(1'b1);
        wait_pd(1'b0);
        for (int t = 0; t < 4; t++) begin
            wait_pd(1'b0);
            repeat (3) @(posedge clk);
            keys <= {rnd(), rnd()};
            d = 16'(rnd());
            wr(7'h42, d);
            rd(2, 7'h16, 16'h0000);
            wait_pd(1'b1);
            if (t > 0) `CHK(int'(($time - t0) / 50), P)
            t0 = $time;
            pins(d);
            len = 0;
            while (return_pulldown_en === 1'b1 && len < 100) begin
                @(negedge clk);
                len++;
            end
            `CHK(len, W)
            repeat (3) @(posedge clk);
            rd(2, 7'h16, 16'h0001);
            rd(2, 7'h16, 16'h0000);
            rd(1, 7'h73, hit(d));
            repeat (5) @(posedge clk);
            rd(1, 7'h73, hit(d));
        end
        fin("scan");
        for (int c = 0; c < 3; c++) begin
            @(posedge clk);
            {display_enable_flag, drive_enable_flag, port_select_flag} <= CFG[c];
            repeat (2) @(posedge clk);
            hits = 0;
            repeat (P + W) begin
                @(negedge clk);
                if (return_pulldown_en !== 1'b0) hits++;
            end
            `CHK(hits, 0)
            if (c != 1) pins(c == 0 ? 16'h0000 : d);
        end
        fin("gating");
        clock_stop <= 1'b1;
        repeat (3) @(posedge clk);
        pins(16'h0000);
        @(negedge clk);
        `CHK({backplane_line_one, backplane_line_zero, upper_seg_outputs}, 16'h0000)
        @(posedge clk);
        clock_stop <= 1'b0;
        rd(0, 7'h42, d);
        fin("stop");
        print_verdict();
    end
endmodule : tb_lcd_key_scan_controller
